// ### verilog/tle_pkg.sv
// Package for the twilight level evaluation block: register map, fields, reset values.
// Assumes an APB master with 32-bit data and word-aligned byte addresses.
package tle_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_CONF_LEVEL = 8'h04;
  localparam logic [7:0] OFF_PRESET = 8'h08;
  localparam logic [7:0] OFF_BRIGHT = 8'h0c;
  localparam logic [7:0] OFF_EVENT = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_ACTIVE_LEVEL = 8'h18;
  localparam logic [7:0] OFF_OFF_MARGIN = 8'h1c;

  // ----------------------------------------
  // Configuration field positions
  // ----------------------------------------
  localparam int CFG_DEP = 0;
  localparam int CFG_APP0 = 1;
  localparam int CFG_TYPE0 = 3;
  localparam int CFG_EXT_DEP = 5;
  localparam int CFG_POL0 = 6;
  localparam int CFG_OVERWRITE = 8;
  localparam int CFG_EXT_SRC = 9;
  localparam int CFG_FIRST_FB = 10;
  localparam int CFG_SIGNAL = 11;
  localparam int CFG_WIDTH = 12;

  // Event register bits (write-one pulses).
  localparam int EV_MOTION = 0;
  localparam int EV_EXT_MOTION = 1;
  localparam int EV_TEACH_VAL = 2;
  localparam int EV_TEACH = 3;
  localparam int EV_DEACT_VAL = 4;
  localparam int EV_DEACT = 5;
  localparam int EV_PROGRAM = 6;
  localparam int EV_BUS_RETURN = 7;
  localparam int EV_DET_END = 8;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RST_LEVEL = 16'h0c1a;
  localparam logic [15:0] RST_MARGIN = 16'h0200;
  localparam logic [CFG_WIDTH-1:0] RST_CONFIG = 12'h001;

  typedef enum logic [1:0] {
    TLE_APP_DETECTOR = 2'b00,
    TLE_APP_CEILING = 2'b01,
    TLE_APP_PRESENCE = 2'b10,
    TLE_APP_LIGHTCTL = 2'b11
  } tle_app_t;

  typedef enum logic [1:0] {
    TLE_TYPE_SINGLE = 2'b00,
    TLE_TYPE_MAIN = 2'b01,
    TLE_TYPE_EXT = 2'b10
  } tle_type_t;

  // Teach polarity: 00 = 0 active, 01 = 1 active, 1x = both active.
  typedef struct packed {
    logic [1:0] teach_pol;
    logic ext_dep;
    logic [1:0] unit_type;
    logic [1:0] app;
    logic dep;
  } tle_cfg_t;

  typedef struct packed {
    logic accept;
    logic switch_off;
  } tle_verdict_t;

endpackage

// ### verilog/tle_core.sv
// Twilight level evaluation for one motion-detection function block, APB slave.
// Assumes a single 10 MHz clock; bus telegrams arrive as writes to the event register.
`timescale 1ns/1ps

module tle_core (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Evaluation results
  output logic accept_pulse,
  output logic detect_active,
  output logic switch_off_pulse,
  output logic level_send_pulse,
  output logic deact_send_pulse,
  output logic deact_out
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic wr;
  logic rd_phase;
  assign wr = psel && penable && pwrite && pready;
  assign rd_phase = psel && !penable;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= tle_pkg::OFF_OFF_MARGIN);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [tle_pkg::CFG_WIDTH-1:0] cfg, next_cfg;
  logic [15:0] conf_level, next_conf_level;
  logic [15:0] active_level, next_active_level;
  logic [15:0] bright, next_bright;
  logic [15:0] margin, next_margin;
  logic bright_valid, next_bright_valid;
  logic deact, next_deact;
  logic detect, next_detect;
  logic bright_lock, next_bright_lock;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic next_level_send, next_deact_send, next_deact_out;

  tle_pkg::tle_cfg_t c;
  assign c = tle_pkg::tle_cfg_t'({cfg[tle_pkg::CFG_POL0+1:tle_pkg::CFG_POL0],
    cfg[tle_pkg::CFG_EXT_DEP], cfg[tle_pkg::CFG_TYPE0+1:tle_pkg::CFG_TYPE0],
    cfg[tle_pkg::CFG_APP0+1:tle_pkg::CFG_APP0], cfg[tle_pkg::CFG_DEP]});

  // ----------------------------------------
  // Evaluation
  // ----------------------------------------
  logic [9:0] ev;
  logic dependent;
  logic is_main, is_single;
  logic dark, too_bright;
  logic [16:0] off_thresh;
  logic int_ok, ext_ok;
  tle_pkg::tle_verdict_t verdict;

  assign ev = (wr && paddr == tle_pkg::OFF_EVENT) ? pwdata[9:0] : 10'h000;
  assign is_main = c.unit_type == tle_pkg::TLE_TYPE_MAIN;
  assign is_single = c.unit_type == tle_pkg::TLE_TYPE_SINGLE;
  // Brightness dependency, with all the forced-independent conditions folded in.
  assign dependent = c.dep
    && c.app != tle_pkg::TLE_APP_DETECTOR
    && !(c.app == tle_pkg::TLE_APP_LIGHTCTL && cfg[tle_pkg::CFG_FIRST_FB])
    && !deact
    && !(cfg[tle_pkg::CFG_EXT_SRC] && !bright_valid);
  assign dark = bright < active_level;
  assign off_thresh = {1'b0, active_level} + {1'b0, margin};
  // A 17-bit sum keeps the threshold from wrapping to a low value near full scale.
  assign too_bright = dependent && c.app == tle_pkg::TLE_APP_PRESENCE
    && ({1'b0, bright} > off_thresh);
  assign int_ok = ev[tle_pkg::EV_MOTION] && (!dependent || dark) && !bright_lock;
  always_comb begin
    ext_ok = 1'b0;
    if (ev[tle_pkg::EV_EXT_MOTION] && !bright_lock) begin
      if (c.unit_type == tle_pkg::TLE_TYPE_EXT) begin
        ext_ok = 1'b0;
      end else if (!dependent) begin
        ext_ok = 1'b1;
      end else if (is_main) begin
        ext_ok = c.ext_dep ? dark : 1'b1;
      end else begin
        ext_ok = c.ext_dep ? dark : 1'b1;
      end
    end
  end
  assign verdict.accept = int_ok || ext_ok;
  assign verdict.switch_off = detect && too_bright && !bright_lock;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_cfg = cfg;
    next_conf_level = conf_level;
    next_active_level = active_level;
    next_bright = bright;
    next_margin = margin;
    next_bright_valid = bright_valid;
    next_deact = deact;
    next_detect = detect;
    next_bright_lock = bright_lock;
    next_level_send = 1'b0;
    next_deact_send = 1'b0;
    next_deact_out = deact_out;
    if (wr) begin
      unique case (paddr)
        tle_pkg::OFF_CONFIG: next_cfg = pwdata[tle_pkg::CFG_WIDTH-1:0];
        tle_pkg::OFF_CONF_LEVEL: next_conf_level = pwdata[15:0];
        tle_pkg::OFF_PRESET: next_active_level = pwdata[15:0];
        tle_pkg::OFF_BRIGHT: begin
          next_bright = pwdata[15:0];
          next_bright_valid = 1'b1;
        end
        tle_pkg::OFF_OFF_MARGIN: next_margin = pwdata[15:0];
        default: ;
      endcase
    end
    // Teach works regardless of the block-disable function.
    if (ev[tle_pkg::EV_TEACH]) begin
      if (c.teach_pol[1] || ev[tle_pkg::EV_TEACH_VAL] == c.teach_pol[0]) begin
        next_active_level = bright;
      end else begin
        next_active_level = conf_level;
      end
    end
    if (ev[tle_pkg::EV_PROGRAM] && cfg[tle_pkg::CFG_OVERWRITE]) begin
      next_active_level = conf_level;
    end
    if (ev[tle_pkg::EV_DEACT]) begin
      next_deact = ev[tle_pkg::EV_DEACT_VAL];
    end
    // The end is applied first, so a start or a lock in the same cycle wins over it.
    if (ev[tle_pkg::EV_DET_END]) begin
      next_detect = 1'b0;
      next_bright_lock = 1'b0;
    end
    if (verdict.accept) begin
      next_detect = 1'b1;
    end
    if (verdict.switch_off) begin
      next_bright_lock = 1'b1;
    end
    if (cfg[tle_pkg::CFG_SIGNAL] && (next_active_level != active_level
        || ev[tle_pkg::EV_PROGRAM] || ev[tle_pkg::EV_BUS_RETURN])) begin
      next_level_send = 1'b1;
    end
    // The main unit mirrors its evaluation state to the extensions while enabled.
    if (is_main && !deact) begin
      next_deact_out = !dependent;
      if (!dependent != deact_out) begin
        next_deact_send = 1'b1;
      end
    end
    if (!is_main && !is_single) begin
      next_deact_out = 1'b0;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (rd_phase) begin
      next_pready = 1'b1;
      next_pslverr = !is_mapped(paddr);
      unique case (paddr)
        tle_pkg::OFF_CONFIG: next_prdata = {20'h00000, cfg};
        tle_pkg::OFF_CONF_LEVEL: next_prdata = {16'h0000, conf_level};
        tle_pkg::OFF_PRESET: next_prdata = {16'h0000, active_level};
        tle_pkg::OFF_BRIGHT: next_prdata = {16'h0000, bright};
        tle_pkg::OFF_STATUS: next_prdata = {27'h0000000, bright_valid, bright_lock,
          dependent, deact, detect};
        tle_pkg::OFF_ACTIVE_LEVEL: next_prdata = {16'h0000, active_level};
        tle_pkg::OFF_OFF_MARGIN: next_prdata = {16'h0000, margin};
        default: next_prdata = 32'h0000_0000;
      endcase
    end else if (psel && penable && !pready) begin
      next_pready = 1'b1;
      next_prdata = prdata;
      next_pslverr = pslverr;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= tle_pkg::RST_CONFIG;
      conf_level <= tle_pkg::RST_LEVEL;
      active_level <= tle_pkg::RST_LEVEL;
      bright <= 16'h0000;
      margin <= tle_pkg::RST_MARGIN;
      bright_valid <= 1'b0;
      deact <= 1'b0;
      detect <= 1'b0;
      bright_lock <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      accept_pulse <= 1'b0;
      detect_active <= 1'b0;
      switch_off_pulse <= 1'b0;
      level_send_pulse <= 1'b0;
      deact_send_pulse <= 1'b0;
      deact_out <= 1'b0;
    end else begin
      cfg <= next_cfg;
      conf_level <= next_conf_level;
      active_level <= next_active_level;
      bright <= next_bright;
      margin <= next_margin;
      bright_valid <= next_bright_valid;
      deact <= next_deact;
      detect <= next_detect;
      bright_lock <= next_bright_lock;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      accept_pulse <= verdict.accept;
      detect_active <= next_detect;
      switch_off_pulse <= verdict.switch_off;
      level_send_pulse <= next_level_send;
      deact_send_pulse <= next_deact_send;
      deact_out <= next_deact_out;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_detector_indep;
    @(posedge pclk) disable iff (!presetn)
      (c.app == tle_pkg::TLE_APP_DETECTOR && ev[tle_pkg::EV_MOTION] && !bright_lock)
      |=> accept_pulse;
  endproperty
  a_detector_indep: assert property (p_detector_indep) else $error("detector motion lost");

  property p_dark_only;
    @(posedge pclk) disable iff (!presetn)
      (dependent && ev[tle_pkg::EV_MOTION] && !ev[tle_pkg::EV_EXT_MOTION] && !dark)
      |=> !accept_pulse;
  endproperty
  a_dark_only: assert property (p_dark_only) else $error("bright motion accepted");

  property p_ext_none;
    @(posedge pclk) disable iff (!presetn)
      (c.unit_type == tle_pkg::TLE_TYPE_EXT && !ev[tle_pkg::EV_MOTION]) |=> !accept_pulse;
  endproperty
  a_ext_none: assert property (p_ext_none) else $error("extension took ext motion");

  property p_ext_indep;
    @(posedge pclk) disable iff (!presetn)
      (!dependent && c.unit_type != tle_pkg::TLE_TYPE_EXT && !bright_lock
       && ev[tle_pkg::EV_EXT_MOTION]) |=> accept_pulse;
  endproperty
  a_ext_indep: assert property (p_ext_indep) else $error("ext motion dropped");

  property p_preset;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == tle_pkg::OFF_PRESET && ev == 10'h000)
      |=> active_level == $past(pwdata[15:0]);
  endproperty
  a_preset: assert property (p_preset) else $error("preset not taken");

  property p_teach_restore;
    @(posedge pclk) disable iff (!presetn)
      (ev[tle_pkg::EV_TEACH] && !c.teach_pol[1] && !ev[tle_pkg::EV_PROGRAM]
       && ev[tle_pkg::EV_TEACH_VAL] != c.teach_pol[0]) |=> active_level == $past(conf_level);
  endproperty
  a_teach_restore: assert property (p_teach_restore) else $error("teach reset failed");

  property p_deact;
    @(posedge pclk) disable iff (!presetn)
      ev[tle_pkg::EV_DEACT] |=> (deact == $past(ev[tle_pkg::EV_DEACT_VAL]))
      && (!deact || !dependent);
  endproperty
  a_deact: assert property (p_deact) else $error("deactivation not applied");

  property p_deact_mute;
    @(posedge pclk) disable iff (!presetn)
      deact |=> !deact_send_pulse;
  endproperty
  a_deact_mute: assert property (p_deact_mute) else $error("muted output sent");

  property p_no_off_indep;
    @(posedge pclk) disable iff (!presetn)
      !dependent |=> !switch_off_pulse;
  endproperty
  a_no_off_indep: assert property (p_no_off_indep) else $error("switch-off when independent");

  property p_ext_main_dark;
    @(posedge pclk) disable iff (!presetn)
      (dependent && is_main && c.ext_dep && ev[tle_pkg::EV_EXT_MOTION]
       && !ev[tle_pkg::EV_MOTION] && !dark) |=> !accept_pulse;
  endproperty
  a_ext_main_dark: assert property (p_ext_main_dark) else $error("bright ext accepted");

  property p_ext_main_both;
    @(posedge pclk) disable iff (!presetn)
      (dependent && is_main && !c.ext_dep && ev[tle_pkg::EV_EXT_MOTION] && !bright_lock)
      |=> accept_pulse;
  endproperty
  a_ext_main_both: assert property (p_ext_main_both) else $error("ext motion lost");

  property p_lightctl_indep;
    @(posedge pclk) disable iff (!presetn)
      (c.app == tle_pkg::TLE_APP_LIGHTCTL && cfg[tle_pkg::CFG_FIRST_FB]
       && ev[tle_pkg::EV_MOTION] && !bright_lock) |=> accept_pulse;
  endproperty
  a_lightctl_indep: assert property (p_lightctl_indep) else $error("light ctl gated");

  property p_teach_adopt;
    @(posedge pclk) disable iff (!presetn)
      (ev[tle_pkg::EV_TEACH] && !ev[tle_pkg::EV_PROGRAM]
       && (c.teach_pol[1] || ev[tle_pkg::EV_TEACH_VAL] == c.teach_pol[0]))
      |=> active_level == $past(bright);
  endproperty
  a_teach_adopt: assert property (p_teach_adopt) else $error("teach not adopted");

  property p_program_restore;
    @(posedge pclk) disable iff (!presetn)
      (ev[tle_pkg::EV_PROGRAM] && cfg[tle_pkg::CFG_OVERWRITE])
      |=> active_level == $past(conf_level);
  endproperty
  a_program_restore: assert property (p_program_restore) else $error("no overwrite");

  property p_level_send;
    @(posedge pclk) disable iff (!presetn)
      (cfg[tle_pkg::CFG_SIGNAL] && (ev[tle_pkg::EV_PROGRAM] || ev[tle_pkg::EV_BUS_RETURN]))
      |=> level_send_pulse;
  endproperty
  a_level_send: assert property (p_level_send) else $error("level not signalled");

  property p_lock_ignore;
    @(posedge pclk) disable iff (!presetn)
      bright_lock |=> !accept_pulse;
  endproperty
  a_lock_ignore: assert property (p_lock_ignore) else $error("locked motion accepted");

  property p_deact_follow;
    @(posedge pclk) disable iff (!presetn)
      (is_main && !deact && !dependent) |=> deact_out;
  endproperty
  a_deact_follow: assert property (p_deact_follow) else $error("deact out not driven");

endmodule

// ### tb/tle_ext_model.sv
// Behavioural extension unit that listens to the deactivation telegram of a main unit.
// Assumes telegrams arrive as one-cycle send pulses with the telegram value alongside.
`timescale 1ns/1ps

module tle_ext_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Telegram from the main unit
  input wire logic deact_send_pulse,
  input wire logic deact_out,
  // Extension state, high while brightness-independent
  output logic ext_indep
);
  // The extension takes deact_out at the edge that ends the telegram cycle, so it lags the main unit by one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_indep <= 1'b0;
    end else if (deact_send_pulse) begin
      ext_indep <= deact_out;
    end
  end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the twilight level evaluation block.
// Assumes an APB slave that answers after one access cycle and events written to EVENT.
`timescale 1ns/1ps

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module testbench;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr, accept_pulse, detect_active;
  logic switch_off_pulse, level_send_pulse, deact_send_pulse, deact_out, ext_indep;
  logic [32:0] q_rd [$];
  logic q_acc [$];
  logic [32:0] exp_r;
  logic exp_a;
  logic pend = 1'b0;
  logic [15:0] lv;
  int n_errors = 0;
  int n_tests = 0;
  int n_off = 0;
  int n_lvl = 0;
  int n_cyc = 0;
  int n0;
  // Motion table: config, event bits, brightness, accepted.
  logic [11:0] t_cfg [11] = '{12'h001, 12'h005, 12'h005, 12'h004, 12'h407, 12'h025,
                             12'h005, 12'h02d, 12'h00d, 12'h02c, 12'h014};
  logic [1:0] t_ev [11] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
  logic [15:0] t_br [11] = '{16'hffff, 16'h0100, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
                             16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h0100};
  logic t_acc [11] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  tle_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .accept_pulse(accept_pulse), .detect_active(detect_active),
    .switch_off_pulse(switch_off_pulse), .level_send_pulse(level_send_pulse),
    .deact_send_pulse(deact_send_pulse), .deact_out(deact_out));

  tle_ext_model i_ext (.pclk(pclk), .presetn(presetn), .deact_send_pulse(deact_send_pulse),
    .deact_out(deact_out), .ext_indep(ext_indep));

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    q_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // Ends any running detection first, so every motion meets an idle block.
  task automatic motion(input logic [11:0] cfg, input logic [31:0] ev,
                        input logic [15:0] br, input logic e);
    wr(tle_pkg::OFF_CONFIG, {20'h0, cfg});
    wr(tle_pkg::OFF_BRIGHT, {16'h0, br});
    wr(tle_pkg::OFF_EVENT, 32'h100);
    q_acc.push_back(e);
    wr(tle_pkg::OFF_EVENT, ev);
  endtask

  task automatic off_case(input logic [11:0] cfg, input int exp_n);
    motion(cfg, 32'h1, 16'h0100, 1'b1);
    n0 = n_off;
    wr(tle_pkg::OFF_BRIGHT, 32'hffff);
    repeat (3) @(posedge pclk);
    `CHK("switch_off count", exp_n, n_off - n0)
    // Dark again, so only the lock can hold the next motion back.
    wr(tle_pkg::OFF_BRIGHT, 32'h0100);
    q_acc.push_back(exp_n == 0);
    wr(tle_pkg::OFF_EVENT, 32'h1);
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock, monitor and timeout
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Outputs are registered, so values read at the edge are those of the ending cycle.
  always @(posedge pclk) begin
    if (pend) begin
      exp_a = q_acc.pop_front();
      `CHK("accept_pulse", exp_a, accept_pulse)
    end
    pend = psel && penable && pready && pwrite && paddr == tle_pkg::OFF_EVENT &&
           pwdata[1:0] != 2'b00;
    if (psel && penable && pready && !pwrite) begin
      exp_r = q_rd.pop_front();
      `CHK("read pslverr and prdata", exp_r, {pslverr, prdata})
    end
    if (switch_off_pulse === 1'b1) n_off++;
    if (level_send_pulse === 1'b1) n_lvl++;
    n_cyc++;
    if (n_cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(82962));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(tle_pkg::OFF_CONFIG, {21'h0, tle_pkg::RST_CONFIG});
    rd(tle_pkg::OFF_ACTIVE_LEVEL, {17'h0, tle_pkg::RST_LEVEL});
    rd(tle_pkg::OFF_OFF_MARGIN, {17'h0, tle_pkg::RST_MARGIN});
    rd(8'h20, {1'b1, 32'h0});
    rd(8'h02, {1'b1, 32'h0});
    for (int i = 0; i < 11; i++) begin
      motion(t_cfg[i], {30'h0, t_ev[i]}, t_br[i], t_acc[i]);
    end
    off_case(12'h005, 1);
    off_case(12'h004, 0);
    // A level of at least 0x1000 can never equal the reset level, so it is a real change.
    lv = 16'h1000 | 16'($urandom_range(0, 4095));
    wr(tle_pkg::OFF_CONFIG, 32'h800);
    n0 = n_lvl;
    wr(tle_pkg::OFF_PRESET, {16'h0, lv});
    repeat (3) @(posedge pclk);
    `CHK("level send count", 1, n_lvl - n0)
    rd(tle_pkg::OFF_ACTIVE_LEVEL, {17'h0, lv});
    wr(tle_pkg::OFF_EVENT, 32'h40);
    rd(tle_pkg::OFF_ACTIVE_LEVEL, {17'h0, lv});
    wr(tle_pkg::OFF_CONFIG, 32'h100);
    wr(tle_pkg::OFF_EVENT, 32'h40);
    rd(tle_pkg::OFF_ACTIVE_LEVEL, {17'h0, tle_pkg::RST_LEVEL});
    wr(tle_pkg::OFF_CONFIG, 32'h040);
    wr(tle_pkg::OFF_BRIGHT, 32'h0555);
    wr(tle_pkg::OFF_EVENT, 32'h0c);
    rd(tle_pkg::OFF_ACTIVE_LEVEL, {17'h0, 16'h0555});
    wr(tle_pkg::OFF_EVENT, 32'h08);
    rd(tle_pkg::OFF_ACTIVE_LEVEL, {17'h0, tle_pkg::RST_LEVEL});
    wr(tle_pkg::OFF_CONFIG, 32'h080);
    wr(tle_pkg::OFF_BRIGHT, 32'h0666);
    wr(tle_pkg::OFF_EVENT, 32'h08);
    rd(tle_pkg::OFF_ACTIVE_LEVEL, {17'h0, 16'h0666});
    wr(tle_pkg::OFF_CONFIG, 32'h100);
    wr(tle_pkg::OFF_EVENT, 32'h40);
    wr(tle_pkg::OFF_EVENT, 32'h30);
    motion(12'h005, 32'h1, 16'hffff, 1'b1);
    motion(12'h00d, 32'h1, 16'hffff, 1'b1);
    wr(tle_pkg::OFF_EVENT, 32'h20);
    `CHK("detect_active", 1'b1, detect_active)
    motion(12'h005, 32'h1, 16'hffff, 1'b0);
    // A deactivated main unit must not pass its new state on to the extensions.
    wr(tle_pkg::OFF_EVENT, 32'h30);
    wr(tle_pkg::OFF_CONFIG, 32'h00d);
    repeat (3) @(posedge pclk);
    `CHK("muted deact_out", 1'b0, deact_out)
    wr(tle_pkg::OFF_EVENT, 32'h20);
    wr(tle_pkg::OFF_CONFIG, 32'h00c);
    wr(tle_pkg::OFF_CONFIG, 32'h00d);
    repeat (3) @(posedge pclk);
    `CHK("extension state", 1'b0, ext_indep)
    wr(tle_pkg::OFF_CONFIG, 32'h00c);
    repeat (3) @(posedge pclk);
    `CHK("extension state", 1'b1, ext_indep)
    // Let the last pulses be checked before the second reset clears them.
    repeat (2) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wr(tle_pkg::OFF_CONFIG, 32'h205);
    // A zero level leaves nothing dark, so only the missing brightness lets motion pass.
    wr(tle_pkg::OFF_PRESET, 32'h0);
    wr(tle_pkg::OFF_EVENT, 32'h100);
    q_acc.push_back(1'b1);
    wr(tle_pkg::OFF_EVENT, 32'h1);
    motion(12'h205, 32'h1, 16'hffff, 1'b0);
    repeat (5) @(posedge pclk);
    report_and_stop();
  end
endmodule
